/* hw/uhim_regs.sv */
// APB register bank for interrupt enable set/clear and the comm-area base address.
//
// Operation
// [RL1] Writing one to a mask-clear bit clears the matching enable bit.
// [RL2] Writing zero to a mask-clear bit leaves the enable bit unchanged.
// [RL3] Reading mask-clear returns the live enable register contents.
// [RL4] Layout: master 31, ownership 30, reserved 29..7, events 6..0.
// [RL5] Enables 2..0 gate frame start, done-head writeback, overrun; reset zero.
// [RL6] Master enable reads as set after any reset.
// [RL7] Comm-area base holds read-write address bits 31..8, reset zero.
// [RL8] Comm-area base bits 7..0 always read zero.
// [RL9] Software finds alignment by writing ones and counting low zeros.
// [RL10] Software writes zeros to comm-area base bits 7..0.
// [RL11] Interrupt requested when status, its enable and master enable all set.
// [RL12] Writing one to mask-set sets the enable bit; zero leaves it.
// [RL13] Reserved enable bits read zero and ignore writes.
//
// The APB register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module uhim_regs
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [6:0] event_pulse,
  input wire logic ownership_event,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic [31:0] comm_area_base,
  output logic [31:0] irq_enable
);
  import uhim_pkg::*;

  logic [31:0] enable_ff;
  logic [31:0] nxt_enable;
  logic [31:0] comm_ff;
  logic [31:0] nxt_comm;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic pready_ff;
  logic nxt_pready;
  logic irq_ff;
  logic nxt_irq;
  logic [31:0] status;
  logic [31:0] event_vec;
  logic [31:0] unread_bits;
  logic status_read;
  logic setup;

  // Decodes whether an address hits one of the four registers.
  function automatic logic addr_hit(input logic [31:0] a);
    addr_hit = (a == UHIM_OFS_STATUS) || (a == UHIM_OFS_MASK_SET) ||
               (a == UHIM_OFS_MASK_CLEAR) || (a == UHIM_OFS_COMM_BASE);
  endfunction

  // Setup cycle of a transfer; the slave answers in the following access cycle.
  assign setup = psel && !penable;
  assign status_read = psel && penable && pready_ff && !pwrite && (paddr == UHIM_OFS_STATUS);
  // An event that lands after the read data was captured is re-set by the clear, so it is not lost unseen.
  assign unread_bits = status_read ? (status & ~prdata_ff) : 32'h00000000;
  assign event_vec = {1'b0, ownership_event, 23'h000000, event_pulse} | unread_bits;

  // Sticky event flags; reading the status register clears them.
  uhim_event_status #(.WIDTH(32)) u_status
  (
    .pclk(pclk),
    .presetn(presetn),
    .event_in(event_vec),
    .valid_bits(UHIM_EVENT_MASK),
    .clear_on_read(status_read),
    .status(status)
  );

  // No wait state: pready rises in the first access cycle, keeping read data registered.
  always_comb
  begin
    nxt_pready = setup;
    nxt_pslverr = setup && !addr_hit(paddr);
    nxt_prdata = 32'h00000000;
    if (setup && !pwrite)
    begin
      unique case (paddr)
        UHIM_OFS_STATUS: nxt_prdata = status;
        UHIM_OFS_MASK_SET: nxt_prdata = enable_ff & UHIM_ENABLE_MASK; // RL13
        UHIM_OFS_MASK_CLEAR: nxt_prdata = enable_ff & UHIM_ENABLE_MASK; // RL3
        UHIM_OFS_COMM_BASE: nxt_prdata = comm_ff & UHIM_COMM_FIELD; // RL8
        default: nxt_prdata = 32'h00000000;
      endcase
    end
  end

  // Write side effects take place only at the completing edge of the access phase.
  always_comb
  begin
    nxt_enable = enable_ff;
    nxt_comm = comm_ff;
    if (psel && penable && pready_ff && pwrite)
    begin
      unique case (paddr)
        UHIM_OFS_MASK_SET: nxt_enable = enable_ff | (pwdata & UHIM_ENABLE_MASK); // RL12
        UHIM_OFS_MASK_CLEAR: nxt_enable = enable_ff & ~(pwdata & UHIM_ENABLE_MASK); // RL1 RL2
        UHIM_OFS_COMM_BASE: nxt_comm = pwdata & UHIM_COMM_FIELD; // RL7
        default: nxt_enable = enable_ff;
      endcase
    end
    nxt_enable = nxt_enable & UHIM_ENABLE_MASK; // RL4 RL13
  end

  // A pending unmasked event raises the interrupt only while the master enable is set.
  always_comb
  begin
    nxt_irq = enable_ff[UHIM_BIT_MASTER] && |(status & enable_ff & UHIM_EVENT_MASK); // RL11
  end

  // Register bank state; master enable starts set, event enables start clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_ff <= UHIM_ENABLE_RESET; // RL5 RL6
      comm_ff <= UHIM_COMM_RESET;
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
      pready_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      enable_ff <= nxt_enable;
      comm_ff <= nxt_comm;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
      pready_ff <= nxt_pready;
      irq_ff <= nxt_irq;
    end
  end

  // Outputs straight from flip-flops.
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;
  assign comm_area_base = comm_ff;
  assign irq_enable = enable_ff;
endmodule
`default_nettype wire

/* hw/uhim_pkg.sv */
// Package of register map, field positions and reset values for the interrupt mask and comm-area block.
package uhim_pkg;
  // Byte addresses of the registers, full system address.
  localparam logic [31:0] UHIM_OFS_STATUS = 32'h9010100c;
  localparam logic [31:0] UHIM_OFS_MASK_SET = 32'h90101010;
  localparam logic [31:0] UHIM_OFS_MASK_CLEAR = 32'h90101014;
  localparam logic [31:0] UHIM_OFS_COMM_BASE = 32'h90101018;
  // Field positions of the enable and status layout.
  localparam int UHIM_BIT_MASTER = 31;
  localparam int UHIM_BIT_OWNERSHIP = 30;
  localparam int UHIM_NUM_EVENTS = 7;
  localparam int UHIM_COMM_LSB = 8;
  // Writable bits of the enable register: master, ownership and the seven event enables.
  localparam logic [31:0] UHIM_ENABLE_MASK = 32'hc000007f;
  // Event bits only, master excluded.
  localparam logic [31:0] UHIM_EVENT_MASK = 32'h4000007f;
  // Reset values.
  localparam logic [31:0] UHIM_ENABLE_RESET = 32'h80000000;
  localparam logic [31:0] UHIM_COMM_RESET = 32'h00000000;
  localparam logic [31:0] UHIM_COMM_FIELD = 32'hffffff00;
endpackage

/* hw/uhim_event_status.sv */
// Sticky event status bits, cleared by a read, with the set winning over the clear.
`timescale 1ns/10ps
`default_nettype none
module uhim_event_status
#(
  parameter int WIDTH = 32
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] event_in,
  input wire logic [WIDTH-1:0] valid_bits,
  input wire logic clear_on_read,
  output logic [WIDTH-1:0] status
);
  logic [WIDTH-1:0] status_ff;
  logic [WIDTH-1:0] nxt_status;

  // An event in the clearing cycle survives, so no event is lost to a read.
  always_comb
  begin
    nxt_status = clear_on_read ? '0 : status_ff;
    nxt_status = (nxt_status | event_in) & valid_bits;
  end

  // Register the status.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_ff <= '0;
    else
      status_ff <= nxt_status;
  end

  assign status = status_ff;
endmodule
`default_nettype wire

/* verification/uhim_checker.sv */
// Concurrent checks on the register bank ports.
`timescale 1ns/10ps
`default_nettype none
module uhim_checker
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [6:0] event_pulse,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic irq,
  input wire logic [31:0] comm_area_base,
  input wire logic [31:0] irq_enable
);
  import uhim_pkg::*;
  // All checks sleep through reset, so stale reset values never fire them.
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A transfer to one address completes where ready is seen.
  sequence s_done(a);
    psel && penable && pready && paddr == a;
  endsequence
  a_clear_bits: assert property (s_done(UHIM_OFS_MASK_CLEAR) ##0 pwrite
    |=> irq_enable == ($past(irq_enable) & ~$past(pwdata))) else $error("mask clear wrong");
  a_set_bits: assert property (s_done(UHIM_OFS_MASK_SET) ##0 pwrite
    |=> irq_enable == ($past(irq_enable) | ($past(pwdata) & UHIM_ENABLE_MASK))) else $error("mask set wrong");
  a_clear_readback: assert property (s_done(UHIM_OFS_MASK_CLEAR) ##0 !pwrite
    |-> prdata == irq_enable) else $error("readback wrong");
  a_rsvd_zero: assert property ((irq_enable & ~UHIM_ENABLE_MASK) == 32'h0) else $error("reserved set");
  a_comm_write: assert property (s_done(UHIM_OFS_COMM_BASE) ##0 pwrite
    |=> comm_area_base == ($past(pwdata) & UHIM_COMM_FIELD)) else $error("base write wrong");
  a_comm_low: assert property (comm_area_base[7:0] == 8'h00) else $error("base low bits set");
  a_irq_master: assert property (irq |-> $past(irq_enable[31])) else $error("irq without master");
  a_irq_raise: assert property (irq_enable[31] && irq_enable[0] && event_pulse[0] && !psel
    |-> ##2 irq) else $error("irq missing");
endmodule
`default_nettype wire

/* verification/uhim_regs_tb.sv */
// Self-checking bench for the mask and base register bank.
`timescale 1ns/10ps
`default_nettype none
module uhim_regs_tb;
  import uhim_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, ownership_event = 1'h0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, comm_area_base, irq_enable, r;
  logic [6:0] event_pulse = 7'h0;
  logic pready, pslverr, irq;
  logic [32:0] exp_q[$];
  int fails = 0, check_count = 0;
  uhim_regs i_uhim_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .event_pulse,
    .ownership_event, .prdata, .pready, .pslverr, .irq, .comm_area_base, .irq_enable);
  // Clock generator.
  initial forever #5 pclk = ~pclk;
  task automatic check(input string n, input logic [32:0] s, e);
    check_count++;
    if (s !== e)
    begin
      fails++;
      $display("Error %s exp %h seen %h", n, e, s);
    end
  endtask
  // Reads note their expected error flag and data for the monitor.
  task automatic apb(input logic w, input logic [31:0] a, d, input logic [32:0] e = 33'h0);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    if (!w)
      exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    {psel, penable} <= 2'h0;
  endtask
  task automatic pulse(input int i, input logic e);
    @(posedge pclk);
    event_pulse <= 7'h1 << i;
    @(posedge pclk);
    event_pulse <= 7'h0;
    repeat (2) @(posedge pclk);
    check("irq", {32'h0, irq}, {32'h0, e});
  endtask
  task automatic print_verdict;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Read data is compared only when the access phase completes.
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
      check("prdata", {pslverr, prdata}, exp_q.pop_front());
  // Watchdog, far beyond the roughly 110 cycles the tests need.
  initial
  begin
    repeat (3000) @(posedge pclk);
    fails++;
    print_verdict;
  end
  initial
  begin
    void'($urandom(82));
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, UHIM_OFS_MASK_CLEAR, 32'h0, {1'h0, UHIM_ENABLE_RESET});
    apb(1'h0, UHIM_OFS_COMM_BASE, 32'h0, 33'h0);
    apb(1'h1, UHIM_OFS_MASK_SET, 32'hffffffff);
    apb(1'h0, UHIM_OFS_MASK_CLEAR, 32'h0, {1'h0, UHIM_ENABLE_MASK});
    r = $urandom;
    apb(1'h1, UHIM_OFS_MASK_CLEAR, r);
    apb(1'h0, UHIM_OFS_MASK_SET, 32'h0, {1'h0, UHIM_ENABLE_MASK & ~r});
    apb(1'h1, UHIM_OFS_MASK_SET, 32'hffffffff);
    $display("mask tests done");
    for (int i = 0; i < 7; i++)
    begin
      pulse(i, 1'h1);
      apb(1'h0, UHIM_OFS_STATUS, 32'h0, {1'h0, 32'h1 << i});
    end
    @(posedge pclk);
    ownership_event <= 1'h1;
    @(posedge pclk);
    ownership_event <= 1'h0;
    repeat (2) @(posedge pclk);
    check("irq_own", {32'h0, irq}, 33'h1);
    apb(1'h0, UHIM_OFS_STATUS, 32'h0, {1'h0, 32'h40000000});
    apb(1'h1, UHIM_OFS_MASK_CLEAR, 32'h1);
    pulse(0, 1'h0);
    apb(1'h1, UHIM_OFS_MASK_CLEAR, 32'h80000000);
    pulse(1, 1'h0);
    $display("irq tests done");
    apb(1'h1, UHIM_OFS_COMM_BASE, 32'hffffffff);
    apb(1'h0, UHIM_OFS_COMM_BASE, 32'h0, 33'h0ffffff00);
    apb(1'h1, UHIM_OFS_COMM_BASE, r & UHIM_COMM_FIELD);
    apb(1'h0, UHIM_OFS_COMM_BASE, 32'h0, {1'h0, r & UHIM_COMM_FIELD});
    apb(1'h0, 32'h90101000, 32'h0, 33'h100000000);
    $display("base tests done");
    print_verdict;
  end
endmodule
bind uhim_regs uhim_checker i_uhim_checker (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .event_pulse, .prdata, .pready, .irq, .comm_area_base, .irq_enable);
`default_nettype wire
